// ==== exec_pkg.sv ====
// constants, types and register map for the execution datapath
// assumes a single core clock domain; all users import this package
package exec_pkg;

  // widths
  localparam int PC_W   = 12;
  localparam int MEM_AW = 8;
  localparam int REG_AW = 8;
  localparam int REG_DW = 16;

  // register byte offsets
  localparam logic [REG_AW-1:0] OFS_WREG    = 8'h00;
  localparam logic [REG_AW-1:0] OFS_STATUS  = 8'h04;
  localparam logic [REG_AW-1:0] OFS_PC      = 8'h08;
  localparam logic [REG_AW-1:0] OFS_STACK   = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_CTRL    = 8'h10;
  localparam logic [REG_AW-1:0] OFS_MEMPTR  = 8'h14;
  localparam logic [REG_AW-1:0] OFS_MEMDATA = 8'h18;

  // field positions and reset values
  localparam int CTRL_RUN_BIT = 0;
  localparam int FLAG_W       = 4;
  localparam logic [7:0]      WREG_RST  = 8'h00;
  localparam logic [PC_W-1:0] PC_RST    = 12'h000;
  localparam logic            RUN_RST   = 1'b1;
  localparam logic [7:0]      ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0] PC_STEP   = 12'h001;

  // data memory address that aliases the program counter low byte
  localparam logic [MEM_AW-1:0] PCL_ADDR = 8'h06;

  // instruction operations handled here
  typedef enum logic [3:0] {
    OP_ADD_CARRY_TO_W,
    OP_ADD_WITH_CARRY_TO_MEM,
    OP_ADD_MEM_TO_W,
    OP_ADD_IMM_TO_W,
    OP_ADD_INTO_MEMORY,
    OP_AND_MEM_TO_W,
    OP_AND_IMM_TO_W,
    OP_AND_INTO_MEMORY,
    OP_CALL,
    OP_ZERO_FILL_BYTE,
    OP_NOP
  } op_e;

  typedef enum logic [1:0] {
    ALU_ADD,
    ALU_AND,
    ALU_ZERO
  } alu_mode_e;

  // status flags, bit 3 down to bit 0
  typedef struct packed {
    logic sign_wrap_flag;
    logic result_null_flag;
    logic half_carry_flag;
    logic bit7_outflow_flag;
  } flags_s;

  localparam flags_s FLAGS_RST = 4'h0;

  typedef struct packed {
    op_e               code;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        imm;
    logic [PC_W-1:0]   target;
  } op_req_s;

endpackage : exec_pkg

// ==== exec_alu.sv ====
// 8-bit add / and / zero unit with flag generation
// assumes purely combinational use inside the execution datapath
module exec_alu (
  // operands
  input  wire logic                 cin,
  input  wire logic [7:0]           a,
  input  wire logic [7:0]           b,
  input  wire exec_pkg::alu_mode_e  mode,
  // result
  output logic      [7:0]           result,
  output exec_pkg::flags_s          flags
);
  import exec_pkg::*;

  logic [8:0] sum9;
  logic [4:0] low5;
  logic [7:0] and8;

  assign sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign low5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign and8 = a & b;

  assign result = (mode == ALU_ADD) ? sum9[7:0] :
                  (mode == ALU_AND) ? and8 : ZERO_BYTE;

  assign flags.bit7_outflow_flag = sum9[8];
  assign flags.half_carry_flag   = low5[4];
  // overflow: like-signed operands giving an unlike-signed sum
  assign flags.sign_wrap_flag    = (a[7] == b[7]) && (sum9[7] != a[7]);
  assign flags.result_null_flag  = (result == ZERO_BYTE);

endmodule : exec_alu

// ==== exec_datapath.sv ====
// execution datapath: add, and, call and zero-fill with status flags
// assumes issue and register port are driven from logic on MCLK
//
// Contract
// - add-with-carry to w: w = w + mem + carry, four flags updated
// - add-with-carry to memory: mem = w + mem + carry, four flags updated
// - add memory to w without carry-in, result in w, four flags
// - add immediate to w without carry-in, result in w, four flags
// - add w into memory without carry-in, result in memory, four flags
// - and memory into w, only zero flag changes
// - and immediate into w, only zero flag changes
// - and w into memory, only zero flag changes
// - call pushes pc plus one, loads target, leaves flags alone
// - call takes two instruction cycles
// - zero-fill writes 00 to the memory byte, no flag changes
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
module exec_datapath #(
  parameter int STACK_DEPTH = 8
) (
  // clock, reset, enable
  input  wire logic                          MCLK,
  input  wire logic                          RST,
  input  wire logic                          CE,
  // instruction issue
  input  wire logic                          OP_VALID,
  input  wire exec_pkg::op_req_s             OP_REQ,
  output logic                               OP_READY,
  output logic                               OP_DONE,
  // register port
  input  wire logic [exec_pkg::REG_AW-1:0]   REG_ADDR,
  input  wire logic [exec_pkg::REG_DW-1:0]   REG_WDATA,
  input  wire logic                          REG_WR,
  input  wire logic                          REG_RD,
  output logic      [exec_pkg::REG_DW-1:0]   REG_RDATA,
  // state view
  output logic      [7:0]                    WREG_OUT,
  output exec_pkg::flags_s                   FLAGS_OUT,
  output logic      [exec_pkg::PC_W-1:0]     PC_OUT
);
  import exec_pkg::*;

  localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam logic [SPW:0] LEVEL_MAX = (SPW+1)'(STACK_DEPTH);

  generate
    if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin : g_bad_depth
      $error("STACK_DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef enum logic [1:0] {
    S_RUN,
    S_CALL2,
    S_REFILL
  } state_e;

  //////////////////////////////////////////////////////////////////////////////
  // state

  state_e            state_r;
  state_e            state_nxt;
  logic [7:0]        wreg_r;
  logic [7:0]        wreg_nxt;
  flags_s            flags_r;
  flags_s            flags_nxt;
  logic [PC_W-1:0]   pc_r;
  logic [PC_W-1:0]   pc_nxt;
  logic [PC_W-1:0]   call_tgt_r;
  logic [SPW-1:0]    sp_r;
  logic [SPW:0]      level_r;
  logic              run_en_r;
  logic [MEM_AW-1:0] mem_ptr_r;
  logic [REG_DW-1:0] rdata_r;
  logic              done_r;
  logic              done_nxt;

  logic [7:0]        dmem  [0:(1<<MEM_AW)-1];
  logic [PC_W-1:0]   stack [0:STACK_DEPTH-1];

  //////////////////////////////////////////////////////////////////////////////
  // decode

  op_e        op;
  logic       take;
  logic       is_add;
  logic       is_and;
  logic       is_call;
  logic       is_zero;
  logic       use_carry;
  logic       use_imm;
  logic       to_mem;
  logic       to_w;
  logic       pcl_hit;
  logic [7:0] mem_byte;
  logic [7:0] alu_b;
  logic       alu_cin;
  alu_mode_e  alu_mode;
  logic [7:0] result;
  flags_s     alu_flags;
  logic [PC_W-1:0] pc_inc;

  assign op        = OP_REQ.code;
  assign OP_READY  = (state_r == S_RUN) && run_en_r;
  assign take      = CE && OP_VALID && OP_READY;

  assign is_add    = (op == OP_ADD_CARRY_TO_W) || (op == OP_ADD_WITH_CARRY_TO_MEM) ||
                     (op == OP_ADD_MEM_TO_W) || (op == OP_ADD_IMM_TO_W) ||
                     (op == OP_ADD_INTO_MEMORY);
  assign is_and    = (op == OP_AND_MEM_TO_W) || (op == OP_AND_IMM_TO_W) ||
                     (op == OP_AND_INTO_MEMORY);
  assign is_call   = (op == OP_CALL);
  assign is_zero   = (op == OP_ZERO_FILL_BYTE);
  // only the two carry forms feed the old carry back in
  assign use_carry = (op == OP_ADD_CARRY_TO_W) ||
                     (op == OP_ADD_WITH_CARRY_TO_MEM);
  assign use_imm   = (op == OP_ADD_IMM_TO_W) || (op == OP_AND_IMM_TO_W);
  assign to_mem    = (op == OP_ADD_WITH_CARRY_TO_MEM) || (op == OP_ADD_INTO_MEMORY) ||
                     (op == OP_AND_INTO_MEMORY) || is_zero;
  assign to_w      = (is_add || is_and) && !to_mem;
  assign pcl_hit   = to_mem && (OP_REQ.addr == PCL_ADDR);

  // pc low byte is visible at its data memory address
  assign mem_byte  = (OP_REQ.addr == PCL_ADDR) ? pc_r[7:0] : dmem[OP_REQ.addr];
  assign alu_b     = use_imm ? OP_REQ.imm : mem_byte;
  assign alu_cin   = use_carry && flags_r.bit7_outflow_flag;
  assign alu_mode  = is_add ? ALU_ADD : (is_and ? ALU_AND : ALU_ZERO);
  assign pc_inc    = pc_r + PC_STEP;

  exec_alu u_alu (
    .cin    (alu_cin),
    .a      (wreg_r),
    .b      (alu_b),
    .mode   (alu_mode),
    .result (result),
    .flags  (alu_flags)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register port decode

  logic wr_wreg;
  logic wr_status;
  logic wr_pc;
  logic wr_ctrl;
  logic wr_memptr;
  logic wr_memdata;
  logic [REG_DW-1:0] rd_val;

  assign wr_wreg    = REG_WR && (REG_ADDR == OFS_WREG);
  assign wr_status  = REG_WR && (REG_ADDR == OFS_STATUS);
  assign wr_pc      = REG_WR && (REG_ADDR == OFS_PC);
  assign wr_ctrl    = REG_WR && (REG_ADDR == OFS_CTRL);
  assign wr_memptr  = REG_WR && (REG_ADDR == OFS_MEMPTR);
  assign wr_memdata = REG_WR && (REG_ADDR == OFS_MEMDATA);

  assign rd_val =
    (REG_ADDR == OFS_WREG)    ? {8'h00, wreg_r} :
    (REG_ADDR == OFS_STATUS)  ? {12'h000, flags_r} :
    (REG_ADDR == OFS_PC)      ? {4'h0, pc_r} :
    (REG_ADDR == OFS_STACK)   ? REG_DW'(level_r) :
    (REG_ADDR == OFS_CTRL)    ? REG_DW'(run_en_r) :
    (REG_ADDR == OFS_MEMPTR)  ? {8'h00, mem_ptr_r} :
    (REG_ADDR == OFS_MEMDATA) ? {8'h00, dmem[mem_ptr_r]} : 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic; a taken instruction wins over a register write

  always_comb begin
    wreg_nxt = wreg_r;
    if (wr_wreg) begin
      wreg_nxt = REG_WDATA[7:0];
    end
    if (take && to_w) begin
      wreg_nxt = result;
    end
  end

  always_comb begin
    flags_nxt = flags_r;
    if (wr_status) begin
      flags_nxt = flags_s'(REG_WDATA[FLAG_W-1:0]);
    end
    if (take && is_add) begin
      flags_nxt = alu_flags;
    end else if (take && is_and) begin
      flags_nxt.result_null_flag = alu_flags.result_null_flag;
    end
    // call and zero-fill leave every flag as it is
  end

  always_comb begin
    pc_nxt = pc_r;
    case (state_r)
      S_RUN: begin
        if (take && is_call) begin
          pc_nxt = pc_r;
        end else if (take && pcl_hit) begin
          pc_nxt = {pc_r[PC_W-1:8], result};
        end else if (take) begin
          pc_nxt = pc_inc;
        end else if (wr_pc) begin
          pc_nxt = REG_WDATA[PC_W-1:0];
        end
      end
      S_CALL2: begin
        pc_nxt = call_tgt_r;
      end
      S_REFILL: begin
        pc_nxt = pc_r;
      end
      default: begin
        pc_nxt = pc_r;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_RUN: begin
        if (take && is_call) begin
          state_nxt = S_CALL2;
        end else if (take && pcl_hit) begin
          state_nxt = S_REFILL;
        end
      end
      S_CALL2: begin
        state_nxt = S_RUN;
      end
      S_REFILL: begin
        state_nxt = S_RUN;
      end
      default: begin
        state_nxt = S_RUN;
      end
    endcase
  end

  // done marks the edge on which the last cycle of an instruction ended
  assign done_nxt = (take && !is_call && !pcl_hit) || (state_r != S_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // control flops

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r <= S_RUN;
      wreg_r  <= WREG_RST;
      flags_r <= FLAGS_RST;
      pc_r    <= PC_RST;
      done_r  <= 1'b0;
    end else if (CE) begin
      state_r <= state_nxt;
      wreg_r  <= wreg_nxt;
      flags_r <= flags_nxt;
      pc_r    <= pc_nxt;
      done_r  <= done_nxt;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      run_en_r  <= RUN_RST;
      mem_ptr_r <= '0;
      rdata_r   <= '0;
    end else if (CE) begin
      if (wr_ctrl) begin
        run_en_r <= REG_WDATA[CTRL_RUN_BIT];
      end
      if (wr_memptr) begin
        mem_ptr_r <= REG_WDATA[MEM_AW-1:0];
      end
      rdata_r <= REG_RD ? rd_val : '0;
    end
  end

  // call target and return stack; stack wraps when pushed past its depth
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      call_tgt_r <= PC_RST;
      sp_r       <= '0;
      level_r    <= '0;
    end else if (CE && take && is_call) begin
      call_tgt_r <= OP_REQ.target;
      sp_r       <= sp_r + 1'b1;
      if (level_r != LEVEL_MAX) begin
        level_r <= level_r + 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (CE && take && is_call) begin
      stack[sp_r] <= pc_inc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data memory; no reset, contents undefined until written

  always_ff @(posedge MCLK) begin
    if (CE) begin
      if (take && to_mem && !pcl_hit) begin
        dmem[OP_REQ.addr] <= result;
      end else if (wr_memdata) begin
        dmem[mem_ptr_r] <= REG_WDATA[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign OP_DONE   = done_r;
  assign REG_RDATA = rdata_r;
  assign WREG_OUT  = wreg_r;
  assign FLAGS_OUT = flags_r;
  assign PC_OUT    = pc_r;

endmodule : exec_datapath

// ==== exec_datapath_asserts.sv ====
// checker for the execution datapath issue port and flag behaviour
// assumes CE held high across two-cycle ops and one core clock
module exec_datapath_asserts
  import exec_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input wire logic                  MCLK,
  input wire logic                  RST,
  input wire logic                  CE,
  input wire logic                  OP_VALID,
  input wire exec_pkg::op_req_s     OP_REQ,
  input wire logic                  OP_READY,
  input wire logic                  OP_DONE,
  input wire logic                  REG_WR,
  input wire logic [7:0]            WREG_OUT,
  input wire exec_pkg::flags_s      FLAGS_OUT,
  input wire logic [exec_pkg::PC_W-1:0] PC_OUT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire logic       take = CE && OP_VALID && OP_READY;
  wire logic       call = take && OP_REQ.code == OP_CALL;
  wire logic       m_dst = OP_REQ.code inside {OP_ADD_WITH_CARRY_TO_MEM, OP_ADD_INTO_MEMORY,
                                               OP_AND_INTO_MEMORY, OP_ZERO_FILL_BYTE};
  wire logic       long_op = OP_REQ.code == OP_CALL || (m_dst && OP_REQ.addr == PCL_ADDR);
  wire logic       is_and = OP_REQ.code inside {OP_AND_MEM_TO_W, OP_AND_IMM_TO_W, OP_AND_INTO_MEMORY};
  wire logic [8:0] i_sum = {1'b0, WREG_OUT} + {1'b0, OP_REQ.imm};
  wire logic [4:0] i_half = {1'b0, WREG_OUT[3:0]} + {1'b0, OP_REQ.imm[3:0]};
  sequence call_start; call ##1 CE; endsequence
  sequence call_land; !OP_READY ##1 (OP_DONE && OP_READY); endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_short_op_done: assert property (take && !long_op |=> OP_DONE)
    else $error("single cycle op gave no done pulse");
  a_call_two_cycles: assert property (call_start |-> call_land)
    else $error("call did not take two cycles");
  a_call_loads_target: assert property (call_start |=> PC_OUT == $past(OP_REQ.target, 2))
    else $error("call did not load target");
  a_call_flags_kept: assert property (call && !REG_WR ##1 CE && !REG_WR |=>
    FLAGS_OUT == $past(FLAGS_OUT, 2))
    else $error("call changed flags");
  a_and_only_zero: assert property (take && is_and && !REG_WR |=>
    (FLAGS_OUT & 4'hb) == ($past(FLAGS_OUT) & 4'hb))
    else $error("and changed a flag other than zero");
  a_fill_flags_kept: assert property (take && OP_REQ.code == OP_ZERO_FILL_BYTE && !REG_WR |=>
    FLAGS_OUT == $past(FLAGS_OUT))
    else $error("zero fill changed flags");
  a_imm_add_sum: assert property (take && OP_REQ.code == OP_ADD_IMM_TO_W |=>
    WREG_OUT == $past(i_sum[7:0]))
    else $error("immediate add result wrong");
  a_imm_add_flags: assert property (take && OP_REQ.code == OP_ADD_IMM_TO_W |=>
    {FLAGS_OUT.half_carry_flag, FLAGS_OUT.bit7_outflow_flag, FLAGS_OUT.result_null_flag} ==
    {$past(i_half[4]), $past(i_sum[8]), $past(i_sum[7:0]) == 8'h00})
    else $error("immediate add flags wrong");
  a_imm_and_result: assert property (take && OP_REQ.code == OP_AND_IMM_TO_W |=>
    WREG_OUT == ($past(WREG_OUT) & $past(OP_REQ.imm)) &&
    FLAGS_OUT.result_null_flag == (WREG_OUT == 8'h00))
    else $error("immediate and result wrong");
endmodule : exec_datapath_asserts

bind exec_datapath exec_datapath_asserts #(.STACK_DEPTH(STACK_DEPTH)) chk (
  .MCLK(MCLK), .RST(RST), .CE(CE), .OP_VALID(OP_VALID), .OP_REQ(OP_REQ),
  .OP_READY(OP_READY), .OP_DONE(OP_DONE), .REG_WR(REG_WR), .WREG_OUT(WREG_OUT),
  .FLAGS_OUT(FLAGS_OUT), .PC_OUT(PC_OUT));

// ==== exec_datapath_test.sv ====
// self-checking bench for the execution datapath
// assumes the register port reaches memory through MEMPTR and MEMDATA
module exec_datapath_test;
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;
  logic              MCLK = 1'b0;
  logic              RST = 1'b1;
  logic              CE = 1'b1;
  logic              OP_VALID = 1'b0;
  op_req_s           OP_REQ = '0;
  logic [REG_AW-1:0] REG_ADDR = '0;
  logic [REG_DW-1:0] REG_WDATA = '0;
  logic              REG_WR = 1'b0;
  logic              REG_RD = 1'b0;
  logic              OP_READY;
  logic              OP_DONE;
  logic [REG_DW-1:0] REG_RDATA;
  logic [7:0]        WREG_OUT;
  flags_s            FLAGS_OUT;
  logic [PC_W-1:0]   PC_OUT;
  int                errors = 0;
  int                n_checks = 0;
  always #50 MCLK = ~MCLK;
  exec_datapath #(.STACK_DEPTH(8)) dut (
    .MCLK(MCLK), .RST(RST), .CE(CE), .OP_VALID(OP_VALID), .OP_REQ(OP_REQ),
    .OP_READY(OP_READY), .OP_DONE(OP_DONE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .WREG_OUT(WREG_OUT),
    .FLAGS_OUT(FLAGS_OUT), .PC_OUT(PC_OUT));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1;
    check("read data", exp, REG_RDATA);
  endtask : rd
  // done is counted from the take edge, so a missing take shows as a timeout
  task automatic issue(op_e c, logic [7:0] a, logic [7:0] x, logic [PC_W-1:0] t, int cyc);
    int i;
    @(posedge MCLK);
    OP_VALID <= 1'b1;
    OP_REQ <= '{c, a, x, t};
    for (i = 0; i < 20 && OP_READY !== 1'b1; i++) @(posedge MCLK);
    @(posedge MCLK);
    OP_VALID <= 1'b0;
    for (i = 1; i < 20; i++) begin
      #1;
      if (OP_DONE === 1'b1) break;
      @(posedge MCLK);
    end
    check("done delay", 16'(cyc), 16'(i));
    if (i == 20) results();
  endtask : issue
  // returns flags over result
  function automatic logic [11:0] calc(op_e c, logic [7:0] w, m, x, flags_s f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b;
    logic       ci;
    b = (c == OP_ADD_IMM_TO_W || c == OP_AND_IMM_TO_W) ? x : m;
    ci = (c == OP_ADD_CARRY_TO_W || c == OP_ADD_WITH_CARRY_TO_MEM) ? f.bit7_outflow_flag : 1'b0;
    s = w + b + ci;
    h = w[3:0] + b[3:0] + ci;
    if (c == OP_ZERO_FILL_BYTE) return {f, ZERO_BYTE};
    if (c inside {OP_AND_MEM_TO_W, OP_AND_IMM_TO_W, OP_AND_INTO_MEMORY})
      return {f[3], (w & b) == 8'h00, f[1:0], w & b};
    return {(w[7] == b[7]) && (s[7] != w[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction : calc
  task automatic run(op_e c, logic [7:0] w, m, x, flags_s f);
    logic [11:0] e;
    e = calc(c, w, m, x, f);
    wr(OFS_WREG, 16'(w));
    wr(OFS_STATUS, 16'(f));
    wr(OFS_MEMDATA, 16'(m));
    issue(c, 8'h20, x, '0, 1);
    check("flags", 16'(e[11:8]), 16'(FLAGS_OUT));
    if (c inside {OP_ADD_WITH_CARRY_TO_MEM, OP_ADD_INTO_MEMORY, OP_AND_INTO_MEMORY,
                  OP_ZERO_FILL_BYTE}) begin
      check("wreg", 16'(w), 16'(WREG_OUT));
      rd(OFS_MEMDATA, 16'(e[7:0]));
    end else begin
      check("wreg", 16'(e[7:0]), 16'(WREG_OUT));
      rd(OFS_MEMDATA, 16'(m));
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    rd(OFS_WREG, 16'h0000);
    rd(OFS_STATUS, 16'h0000);
    rd(OFS_PC, 16'h0000);
    rd(OFS_CTRL, 16'h0001);
    rd(8'h1c, 16'h0000);
    wr(OFS_MEMPTR, 16'h0020);
    run(OP_ADD_CARRY_TO_W, 8'h7f, 8'h00, 8'h00, 4'h1);
    run(OP_ADD_WITH_CARRY_TO_MEM, 8'hff, 8'h00, 8'h00, 4'h1);
    run(OP_ADD_MEM_TO_W, 8'h80, 8'h80, 8'h00, 4'h1);
    run(OP_ADD_IMM_TO_W, 8'h08, 8'h11, 8'h08, 4'h1);
    run(OP_ADD_INTO_MEMORY, 8'h01, 8'h02, 8'h00, 4'h1);
    run(OP_AND_MEM_TO_W, 8'hf0, 8'h0f, 8'h00, 4'hb);
    run(OP_AND_IMM_TO_W, 8'hff, 8'h00, 8'h3c, 4'h5);
    run(OP_AND_INTO_MEMORY, 8'haa, 8'h55, 8'h00, 4'hf);
    run(OP_ZERO_FILL_BYTE, 8'h33, 8'h5a, 8'h00, 4'ha);
    wr(OFS_PC, 16'h0123);
    wr(OFS_STATUS, 16'h0009);
    issue(OP_CALL, 8'h00, 8'h00, 12'h456, 2);
    check("pc", 16'h0456, 16'(PC_OUT));
    check("flags", 16'h0009, 16'(FLAGS_OUT));
    rd(OFS_STACK, 16'h0001);
    wr(OFS_PC, 16'h0305);
    wr(OFS_WREG, 16'h0010);
    issue(OP_ADD_INTO_MEMORY, PCL_ADDR, 8'h00, '0, 2);
    check("pc", 16'h0315, 16'(PC_OUT));
    // a register write while the enable is low must not land
    CE <= 1'b0;
    wr(OFS_WREG, 16'h00aa);
    CE <= 1'b1;
    rd(OFS_WREG, 16'h0010);
    results();
  end
endmodule : exec_datapath_test
